// ### hdl/low_power_map.svh
`ifndef LOW_POWER_MAP_SVH
`define LOW_POWER_MAP_SVH
// Register byte addresses on the Wishbone slave
`define ADDR_OPTIONS 8'h00
`define ADDR_OPTIONS_THREE 8'h04
`define ADDR_CONTROL 8'h08
`define ADDR_STATUS 8'h0C
// Options register fields
`define OPT_MONITOR_BIT 3
`define OPT_FORCED_MONITOR_BIT 2
`define OPT_DELAY_BIT 4
`define OPT_RESET 8'h10
// Options three register fields
`define SYSTEM_CONFIGURATION_OPTIONS_THREE_SLOW_BIT 0
`define SYSTEM_CONFIGURATION_OPTIONS_THREE_RESET 8'h00
// Control register fields
`define CTL_WATCHDOG_OFF_BIT 0
`define CTL_SERIAL_PORT_BIT 1
`define CTL_TRANSMIT_BIT 2
`define CTL_RECEIVE_BIT 3
`define CTL_SPECIAL_MODE_BIT 4
`define CTL_RESET 8'h00
// Condition flag positions
`define FLAG_STOP_DISABLE 7
`define FLAG_NONMASK_MASK 6
`define FLAG_INT_MASK 4
// Timing
`define WRITE_WINDOW_CYCLES 64
`define SLOW_DIVIDE 16
`define STARTUP_DELAY_CYCLES 4096
`endif

// ### hdl/low_power_pkg.sv
package low_power_pkg;
  typedef enum logic [4:0]
  {
    st_run = 5'h01,
    st_stack = 5'h02,
    st_wait = 5'h04,
    st_stop = 5'h08,
    st_settle = 5'h10
  } power_state_type;
endpackage

// ### hdl/slow_divider_if.sv
interface slow_divider_if;
  logic clock_run;
  logic slow_enable;
  logic tick;
  modport owner (output clock_run, output slow_enable, input tick);
  modport divider (input clock_run, input slow_enable, output tick);
endinterface

// ### hdl/slow_divider.sv
`include "low_power_map.svh"
module slow_divider
  import low_power_pkg::*;
#(
  parameter int divide = `SLOW_DIVIDE
)
(
  input wire logic clk,
  input wire logic sys_rst,
  slow_divider_if.divider link
);
  logic [7:0] count;

  // ****************************************
  // Divide-by stage between oscillator and internal clock
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst || !link.clock_run || !link.slow_enable)
      count <= 8'h00;
    else if (count == 8'(divide - 1))
      count <= 8'h00;
    else
      count <= count + 8'h01;
  end

  // Bypass keeps a tick on every cycle outside stop and settle while the divider is off
  assign link.tick = link.clock_run &&
    (!link.slow_enable || count == 8'(divide - 1));
endmodule

// ### hdl/low_power_mode_control.sv
// Behaviour
// RQ1: On wait instruction, stack registers then suspend until a qualified interrupt.
// RQ2: During wait keep oscillator running, always stop processor core clock.
// RQ3: During wait repeatedly read the address holding stacked condition flags.
// RQ4: Leave wait on any unmasked interrupt, external or internal.
// RQ5: Stop timer in wait only if interrupt mask set and watchdog disabled.
// RQ6: In wait gate serial port, transmitter, receiver when enables clear.
// RQ7: Accepted stop halts every clock including oscillator; state retained.
// RQ8: Enter stop only when stop-disable flag clear, else behave as no-op.
// RQ9: Exit stop on low request pins, reset, or pending edge request.
// RQ10: Stop keeps processor state; reset wakeup does full reset sequence.
// RQ11: Maskable pin wakes stop only when interrupt mask flag clear.
// RQ12: Nonmaskable pin wakes stop always; mask flag chooses service or continue.
// RQ13: Clock monitor enabled at stop entry produces a clock-monitor reset.
// RQ14: On stop exit insert stabilization delay only when startup delay bit set.
// RQ15: Reset sets delay bit; normal modes one write within 64 cycles.
// RQ16: Power-on reset always applies delay; running-clock reset does not.
// RQ17: Slow-mode bit set inserts divide-by-16 before internal clock.
// RQ18: Slow-mode bit clear bypasses divider, normal bus speed.
// RQ19: Slow-mode bit read/write anytime; cleared on stop entry and reset.
// RQ20: Software should avoid clock monitor when bus clock below 200 kHz.
`include "low_power_map.svh"
module low_power_mode_control
  import low_power_pkg::*;
#(
  parameter int startup_delay = `STARTUP_DELAY_CYCLES
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic power_on_rst,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic wait_instruction,
  input wire logic stop_instruction,
  input wire logic stack_done,
  input wire logic [15:0] flags_address,
  input wire logic [7:0] condition_flags,
  input wire logic irq_n,
  input wire logic irq_edge_mode,
  input wire logic nonmaskable_request_pin_n,
  input wire logic reset_pin_n,
  input wire logic internal_interrupt,
  output logic stack_request,
  output logic core_clock_run,
  output logic oscillator_run,
  output logic bus_tick,
  output logic timer_clock_run,
  output logic serial_port_clock_run,
  output logic transmit_clock_run,
  output logic receive_clock_run,
  output logic flags_read,
  output logic [15:0] flags_read_address,
  output logic stop_wake_service,
  output logic stop_wake_continue,
  output logic monitor_reset,
  output logic reset_wake
);
  localparam int delay_width = $clog2(startup_delay + 1);

  power_state_type state;
  power_state_type next_state;
  logic [7:0] options;
  logic [7:0] options_three;
  logic [7:0] control;
  logic [6:0] window_count;
  logic delay_written;
  logic [delay_width-1:0] settle_count;
  logic irq_edge_pending;
  logic irq_last;
  logic ack;
  logic wake_nonmask;
  logic wake_irq;
  logic wake_any;
  logic bus_write;
  logic bus_read;
  logic mapped;
  logic any_rst;
  slow_divider_if divider_link();

  function automatic logic lane_write(input logic [7:0] addr);
    lane_write = bus_write && wb_sel_i[0] && wb_adr_i == addr;
  endfunction

  // ****************************************
  // Wishbone slave
  // ****************************************
  assign bus_write = wb_cyc_i && wb_stb_i && wb_we_i && !ack;
  assign bus_read = wb_cyc_i && wb_stb_i && !wb_we_i && !ack;
  assign mapped = wb_adr_i == `ADDR_OPTIONS ||
    wb_adr_i == `ADDR_OPTIONS_THREE || wb_adr_i == `ADDR_CONTROL ||
    wb_adr_i == `ADDR_STATUS;

  // One wait state: ack the cycle after the strobe, then drop it
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ack <= 1'b0;
    else
      ack <= wb_cyc_i && wb_stb_i && !ack && mapped;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      wb_err_o <= 1'b0;
    else
      wb_err_o <= wb_cyc_i && wb_stb_i && !ack && !wb_err_o && !mapped;
  end
  assign wb_ack_o = ack;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      wb_dat_o <= 32'h0000_0000;
    else if (bus_read)
      case (wb_adr_i)
        `ADDR_OPTIONS: wb_dat_o <= {24'h000000, options};
        `ADDR_OPTIONS_THREE: wb_dat_o <= {24'h000000, options_three};
        `ADDR_CONTROL: wb_dat_o <= {24'h000000, control};
        `ADDR_STATUS: wb_dat_o <= {27'h0000000, state};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
  end

  // Power-on reset also returns the software-visible registers
  assign any_rst = sys_rst || power_on_rst;

  // ****************************************
  // Options register with protected delay bit
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (any_rst)
      window_count <= 7'h00;
    else if (window_count != 7'(`WRITE_WINDOW_CYCLES))
      window_count <= window_count + 7'h01; // see RQ15
  end

  always_ff @(posedge clk)
  begin
    if (any_rst)
      delay_written <= 1'b0;
    else if (lane_write(`ADDR_OPTIONS))
      delay_written <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (any_rst)
      options <= `OPT_RESET; // see RQ15
    else if (lane_write(`ADDR_OPTIONS))
    begin
      options[`OPT_MONITOR_BIT] <= wb_dat_i[`OPT_MONITOR_BIT];
      options[`OPT_FORCED_MONITOR_BIT] <= wb_dat_i[`OPT_FORCED_MONITOR_BIT];
      // Once-only write in the opening window unless in a special mode
      if (control[`CTL_SPECIAL_MODE_BIT] ||
          (!delay_written &&
           window_count != 7'(`WRITE_WINDOW_CYCLES)))
        options[`OPT_DELAY_BIT] <= wb_dat_i[`OPT_DELAY_BIT]; // see RQ15
    end
  end

  // ****************************************
  // Slow mode and control bits
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (any_rst)
      options_three <= `SYSTEM_CONFIGURATION_OPTIONS_THREE_RESET; // see RQ19
    else if (next_state == st_stop && state != st_stop)
      options_three[`SYSTEM_CONFIGURATION_OPTIONS_THREE_SLOW_BIT] <= 1'b0; // see RQ19
    else if (lane_write(`ADDR_OPTIONS_THREE))
      options_three <= wb_dat_i[7:0]; // see RQ19
  end

  always_ff @(posedge clk)
  begin
    if (any_rst)
      control <= `CTL_RESET;
    else if (lane_write(`ADDR_CONTROL))
      control <= wb_dat_i[7:0];
  end

  // ****************************************
  // Wake sources
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irq_last <= 1'b1;
    else
      irq_last <= irq_n;
  end

  // Set wins over the clear on wake
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irq_edge_pending <= 1'b0;
    else if (irq_edge_mode && irq_last && !irq_n)
      irq_edge_pending <= 1'b1;
    else if (state == st_run)
      irq_edge_pending <= 1'b0;
  end

  assign wake_irq = !condition_flags[`FLAG_INT_MASK] &&
    (irq_edge_mode ? (irq_edge_pending || (irq_last && !irq_n))
     : !irq_n); // see RQ11
  assign wake_nonmask = !nonmaskable_request_pin_n; // see RQ12
  assign wake_any = wake_irq || wake_nonmask; // see RQ9

  // ****************************************
  // Mode state machine
  // ****************************************
  always_comb
  begin
    next_state = state;
    case (state)
      st_run:
        if (wait_instruction)
          next_state = st_stack; // see RQ1
        else if (stop_instruction && !condition_flags[`FLAG_STOP_DISABLE])
          next_state = st_stop; // see RQ8
      st_stack:
        if (stack_done)
          next_state = st_wait; // see RQ1
      st_wait:
        if (wake_any || internal_interrupt)
          next_state = st_run; // see RQ4
      st_stop:
        if (wake_any)
          next_state = options[`OPT_DELAY_BIT] ? st_settle : st_run; // see RQ14
      st_settle:
        if (settle_count == '0)
          next_state = st_run;
      default:
        next_state = st_run;
    endcase
  end

  // Power-on reset forces the settle phase whatever the delay bit holds
  always_ff @(posedge clk)
  begin
    if (power_on_rst)
      state <= st_settle; // see RQ16
    else if (sys_rst)
      state <= st_run; // see RQ16
    else
      state <= next_state;
  end

  always_ff @(posedge clk)
  begin
    if (power_on_rst)
      settle_count <= delay_width'(startup_delay - 1);
    else if (state == st_stop)
      settle_count <= delay_width'(startup_delay - 1); // see RQ14
    else if (state == st_settle && settle_count != '0)
      settle_count <= settle_count - 1'b1;
  end

  // ****************************************
  // Wake and reset signalling
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      stop_wake_service <= 1'b0;
      stop_wake_continue <= 1'b0;
    end
    else
    begin
      // Processor state untouched; core resumes or takes the interrupt
      stop_wake_service <= state == st_stop && wake_any &&
        (wake_irq || !condition_flags[`FLAG_NONMASK_MASK]); // see RQ10
      stop_wake_continue <= state == st_stop && wake_nonmask && !wake_irq &&
        condition_flags[`FLAG_NONMASK_MASK]; // see RQ12
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      monitor_reset <= 1'b0;
    else
      monitor_reset <= next_state == st_stop && state != st_stop &&
        (options[`OPT_MONITOR_BIT] ||
         options[`OPT_FORCED_MONITOR_BIT]); // see RQ13
  end

  // A reset pin in stop asks for a full reset sequence from the reset block
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      reset_wake <= 1'b0;
    else
      reset_wake <= state == st_stop && !reset_pin_n; // see RQ9
  end

  // ****************************************
  // Clock gating
  // ****************************************
  assign divider_link.clock_run = state != st_stop && state != st_settle;
  assign divider_link.slow_enable = options_three[`SYSTEM_CONFIGURATION_OPTIONS_THREE_SLOW_BIT]; // see RQ17

  slow_divider #(.divide(`SLOW_DIVIDE)) divider_inst
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .link(divider_link.divider)
  );

  assign bus_tick = divider_link.tick; // see RQ18
  assign stack_request = state == st_stack;
  assign oscillator_run = state != st_stop; // see RQ7
  assign core_clock_run = state == st_run || state == st_stack; // see RQ2
  // Outside stop and settle the timer halts only when nothing can need it: in wait, masked and watchdog off
  assign timer_clock_run = divider_link.clock_run &&
    !(state == st_wait && condition_flags[`FLAG_INT_MASK] &&
      control[`CTL_WATCHDOG_OFF_BIT]); // see RQ5
  assign serial_port_clock_run = divider_link.clock_run &&
    !(state == st_wait && !control[`CTL_SERIAL_PORT_BIT]); // see RQ6
  assign transmit_clock_run = divider_link.clock_run &&
    !(state == st_wait && !control[`CTL_TRANSMIT_BIT]); // see RQ6
  assign receive_clock_run = divider_link.clock_run &&
    !(state == st_wait && !control[`CTL_RECEIVE_BIT]); // see RQ6

  // ****************************************
  // Wait-state flag reads
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (any_rst)
    begin
      flags_read <= 1'b0;
      flags_read_address <= 16'h0000;
    end
    else
    begin
      flags_read <= next_state == st_wait; // see RQ3
      flags_read_address <= flags_address; // see RQ3
    end
  end
endmodule

// ### test/low_power_checker.sv
module low_power_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic stack_request,
  input wire logic flags_read,
  input wire logic core_clock_run,
  input wire logic oscillator_run,
  input wire logic bus_tick,
  input wire logic [15:0] flags_address,
  input wire logic [15:0] flags_read_address,
  input wire logic [7:0] condition_flags,
  input wire logic irq_n,
  input wire logic irq_edge_mode,
  input wire logic nonmaskable_request_pin_n,
  input wire logic reset_pin_n,
  input wire logic internal_interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    && !wb_err_o |=> wb_ack_o || wb_err_o) else $error("no bus answer");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_stack_first: assert property ($rose(flags_read) |->
    $past(stack_request) || $past(stack_request, 2))
    else $error("wait entered without stacking");
  a_wait_core_off: assert property (flags_read |->
    !core_clock_run && oscillator_run) else $error("wait clocks wrong");
  a_wait_address: assert property (flags_read |->
    flags_read_address == flags_address) else $error("wait read address");
  a_wait_leave: assert property (flags_read && internal_interrupt
    && !condition_flags[4] |-> ##[1:2] !flags_read)
    else $error("wait not left");
  a_stop_frozen: assert property (!oscillator_run |->
    !bus_tick && !core_clock_run) else $error("clock runs in stop");
  a_masked_sleep: assert property (!oscillator_run &&
    (irq_n || condition_flags[4]) && nonmaskable_request_pin_n
    && reset_pin_n && !irq_edge_mode |=> !oscillator_run)
    else $error("stop left without cause");
  a_pin_wakes: assert property (!oscillator_run &&
    (!nonmaskable_request_pin_n || (!irq_n && !condition_flags[4]))
    |-> ##[1:2] oscillator_run) else $error("stop not left");
endmodule

bind low_power_mode_control low_power_checker low_power_checker_i (
  .clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_err_o,
  .stack_request, .flags_read, .core_clock_run, .oscillator_run,
  .bus_tick, .flags_address, .flags_read_address, .condition_flags,
  .irq_n, .irq_edge_mode, .nonmaskable_request_pin_n, .reset_pin_n,
  .internal_interrupt
);

// ### test/core_model.sv
module core_model (
  input wire logic clk,
  input wire logic stack_request,
  input wire logic [3:0] lag,
  output logic wait_instruction = 1'b0,
  output logic stop_instruction = 1'b0,
  output logic stack_done = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  int n = 0;
  // Stacking takes lag extra cycles, so a slow core is exercised too
  always @(posedge clk)
  begin
    stack_done <= 1'b0;
    if (stack_request && !stack_done)
    begin
      n <= (n == lag) ? 0 : n + 1;
      stack_done <= (n == lag);
    end
  end
  task issue(input logic stop);
    @(posedge clk);
    stop_instruction <= stop;
    wait_instruction <= !stop;
    @(posedge clk);
    stop_instruction <= 1'b0;
    wait_instruction <= 1'b0;
  endtask
endmodule

// ### test/test_low_power_mode_control.sv
module test_low_power_mode_control;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic w; logic [7:0] a, d, x; logic e;} row_type;
  logic clk = 0, sys_rst = 1, power_on_rst = 0, we = 0, cyc = 0;
  logic irq_n = 1, nm_n = 1, reset_pin_n = 1, internal_interrupt = 0;
  logic clr = 0, e;
  logic edge_mode = 0, sel_off = 0;
  logic [3:0] sel = 4'hF;
  logic [15:0] fa = 16'h01F8;
  logic [7:0] adr = 0, flags = 0, q;
  logic [31:0] wdat = 0;
  logic [3:0] seen = 0, lag = 0;
  wire ack, err, stack_done, wait_ins, stop_ins, stack_request, osc, tick;
  wire flags_read, svc, cont, mon, rwake;
  wire core_run;
  wire [15:0] fra;
  wire [3:0] gates;
  wire [31:0] rdat;
  int err_total = 0, num_checks = 0, n, k;
  // Reads of reset values, one unmapped place, the one-time delay write
  row_type rows [10] = '{'{0, 8'h00, 0, 8'h10, 0}, '{0, 8'h04, 0, 0, 0},
    '{0, 8'h08, 0, 0, 0}, '{0, 8'h0C, 0, 8'h01, 0}, '{0, 8'h10, 0, 0, 1},
    '{1, 8'h00, 0, 0, 0}, '{1, 8'h00, 8'h10, 0, 0}, '{0, 8'h00, 0, 0, 0},
    '{1, 8'h04, 8'h01, 0, 0}, '{0, 8'h04, 0, 8'h01, 0}};

  always #2.5 clk = ~clk;
  always @(posedge clk) seen <= clr ? 4'h0 : seen | {rwake, mon, cont, svc};

  low_power_mode_control #(.startup_delay(12)) low_power_mode_control_i (
    .clk, .sys_rst, .power_on_rst, .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_ack_o(ack), .wb_err_o(err),
    .wait_instruction(wait_ins), .stop_instruction(stop_ins), .stack_done,
    .flags_address(fa), .condition_flags(flags), .irq_n,
    .irq_edge_mode(edge_mode), .nonmaskable_request_pin_n(nm_n),
    .reset_pin_n, .internal_interrupt, .stack_request,
    .core_clock_run(core_run),
    .oscillator_run(osc), .bus_tick(tick), .timer_clock_run(gates[3]),
    .serial_port_clock_run(gates[2]), .transmit_clock_run(gates[1]),
    .receive_clock_run(gates[0]), .flags_read, .flags_read_address(fra),
    .stop_wake_service(svc), .stop_wake_continue(cont),
    .monitor_reset(mon), .reset_wake(rwake));
  core_model core_model_i (.clk, .stack_request, .lag,
    .wait_instruction(wait_ins), .stop_instruction(stop_ins), .stack_done);

  task wrap_up;
    if (err_total == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string s, input logic [7:0] x, input logic [7:0] g);
    num_checks++;
    if (g !== x)
    begin
      $display("wrong value %s expected %h seen %h", s, x, g);
      err_total++;
    end
  endtask
  function automatic logic cond(input int c);
    case (c)
      0: return flags_read === 1'b1;
      1: return flags_read === 1'b0;
      2: return osc === 1'b0;
      default: return tick === 1'b1;
    endcase
  endfunction
  // Bounded wait, so a hung design still reaches the verdict
  task hold(input int c, output int m);
    m = 0;
    while (!cond(c) && m < 50)
    begin
      @(posedge clk);
      m++;
    end
    if (m == 50)
    begin
      err_total++;
      wrap_up;
    end
  endtask
  task bus(input logic w, input logic [7:0] a, d);
    @(posedge clk);
    cyc <= 1;
    sel <= sel_off ? 4'h0 : 4'hF;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    n = 0;
    while (ack !== 1'b1 && err !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 20)
    begin
      err_total++;
      wrap_up;
    end
    q = rdat[7:0];
    e = err;
    cyc <= 0;
    we <= 0;
    @(posedge clk);
  endtask
  task span;
    n = 0;
    repeat (32) @(posedge clk) n += int'(tick === 1'b1);
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    sys_rst <= 0;
    foreach (rows[i])
    begin
      bus(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk("rdata", rows[i].x, q);
      chk("err", rows[i].e, e);
    end
    span;
    chk("slow ticks", 2, n);
    bus(1, 8'h04, 8'h00);
    span;
    chk("fast ticks", 32, n);
    for (k = 0; k < 2; k++)
    begin
      bus(1, 8'h08, k ? 8'h0E : 8'h01);
      flags <= k ? 8'h00 : 8'h10;
      fa <= k ? 16'h01F8 : 16'h8E07;
      lag <= k ? 4'h0 : 4'h3;
      core_model_i.issue(0);
      hold(0, n);
      chk("gates", k ? 4'hF : 4'h0, gates);
      chk("read address", 1, fra === fa);
      chk("core clock", 0, core_run);
      if (k) internal_interrupt <= 1; else nm_n <= 0;
      hold(1, n);
      chk("core resumed", 1, core_run);
      internal_interrupt <= 0;
      nm_n <= 1;
    end
    bus(1, 8'h04, 8'h01);
    flags <= 8'h80;
    core_model_i.issue(1);
    repeat (4) @(posedge clk);
    chk("stop refused", 1, osc);
    flags <= 8'h00;
    core_model_i.issue(1);
    hold(2, n);
    irq_n <= 0;
    hold(3, n);
    irq_n <= 1;
    chk("short gap", 1, n < 4);
    bus(0, 8'h04, 0);
    chk("slow bit", 0, q);
    bus(1, 8'h08, 8'h10);
    bus(1, 8'h00, 8'h10);
    bus(0, 8'h00, 0);
    chk("special delay", 8'h10, q);
    for (k = 0; k < 3; k++)
    begin
      flags <= k == 1 ? 8'h40 : 8'h00;
      if (k == 2) bus(1, 8'h00, 8'h18);
      clr <= 1;
      core_model_i.issue(1);
      clr <= 0;
      hold(2, n);
      if (k == 2) break;
      nm_n <= 0;
      hold(3, n);
      nm_n <= 1;
      chk("long gap", 1, n >= 10);
      chk("wake kind", k ? 2'b10 : 2'b01, seen[1:0]);
    end
    repeat (3) @(posedge clk);
    reset_pin_n <= 0;
    repeat (3) @(posedge clk);
    chk("resets", 2'b11, seen[3:2]);
    reset_pin_n <= 1;
    sys_rst <= 1;
    repeat (5) @(posedge clk);
    sys_rst <= 0;
    hold(3, n);
    chk("reset gap", 1, n < 4);
    bus(0, 8'h00, 0);
    chk("delay reset", 8'h10, q);
    bus(1, 8'h04, 8'h01);
    power_on_rst <= 1;
    @(posedge clk);
    power_on_rst <= 0;
    @(posedge clk);
    hold(3, n);
    chk("power-on gap", 1, n >= 9);
    bus(0, 8'h04, 0);
    chk("slow after power-on", 0, q);
    // A write without lane 0 must leave the register alone
    sel_off = 1;
    bus(1, 8'h04, 8'h01);
    sel_off = 0;
    bus(0, 8'h04, 0);
    chk("lane refused", 0, q);
    edge_mode <= 1;
    core_model_i.issue(1);
    hold(2, n);
    irq_n <= 0;
    @(posedge clk);
    irq_n <= 1;
    hold(3, n);
    chk("edge wake", 1, n >= 9);
    wrap_up;
  end
endmodule
